// ---- common/i2c_stretch_pkg.sv ----
// constants and types for the automatic clock-stretch block
// Summary of operation
// - writing one to shared bit 0 reinitialises start/stop detection
// - that same write also clears the bus-occupied indication
// - bit 9 sets on slave stretch timeout, cleared by reading
// - bit 8 sets on master stretch timeout, cleared by reading
// - slave transmitter holds SCL low from falling edge while Tx FIFO empty
// - slave Tx stretch ends when FIFO has data or on timeout
// - slave receiver holds SCL low before ack while Rx FIFO full
// - slave Rx stretch ends when FIFO leaves full or on timeout
// - slave field 0000 disables; 0001 to 1111 enables, value is exponent
// - slave timeout is (hi+lo-1) divided-clock periods times 2^field
// - slave timeout depends only on divisors and field, not bit rate
// - master transmitter holds SCL low while master Tx FIFO empty
// - master Tx stretch ends when FIFO non-empty or on timeout
// - master receiver holds SCL low before ack while Rx FIFO full
// - master Rx stretch ends when FIFO leaves full or on timeout
// - master field 0000 disables; 1111 stretches with no timeout
// - master timeout is (hi+lo-1) divided-clock periods times 2^field
// - each FIFO holds two bytes; full receive FIFO means two bytes
`default_nettype none
package i2c_stretch_pkg;
  localparam int ADDR_W = 32;
  localparam int REG_W = 16;
  localparam logic [ADDR_W-1:0] SHARED_RESET_ADDR = 32'h40003050;
  localparam logic [ADDR_W-1:0] STRETCH_CTRL_ADDR = 32'h40003058;
  localparam int DETECTOR_RESET_BIT = 0;
  localparam int SET_W = 4;
  localparam int MASTER_SET_LSB = 0;
  localparam int SLAVE_SET_LSB = 4;
  localparam int MASTER_FLAG_BIT = 8;
  localparam int SLAVE_FLAG_BIT = 9;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [SET_W-1:0] STRETCH_OFF = 4'h0;
  localparam logic [SET_W-1:0] STRETCH_FOREVER = 4'hF;
  localparam int FIFO_CNT_W = 2;
  localparam logic [FIFO_CNT_W-1:0] FIFO_DEPTH = 2'h2;
  localparam logic [FIFO_CNT_W-1:0] FIFO_NONE = 2'h0;
  localparam int DIV_W = 8;
  localparam int BASE_W = 9;
  localparam int CLKDIV_W = 3;
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE = 16'h0001;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } stretch_state_t;
endpackage : i2c_stretch_pkg
`default_nettype wire

// ---- hdl/stretch_half.sv ----
// one half (master or slave) of the stretch engine with its timeout
`default_nettype none
module stretch_half
  import i2c_stretch_pkg::*;
#(
  parameter bit ALLOW_FOREVER = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SET_W-1:0] setting,
  input wire logic sclFall,
  input wire logic boundary,
  input wire logic txRole,
  input wire logic rxRole,
  input wire logic txEmpty,
  input wire logic rxFull,
  input wire logic [BASE_W-1:0] baseLen,
  input wire logic [CLKDIV_W-1:0] clkDiv,
  output logic hold,
  output logic timeout
);
  stretch_state_t state_r;
  logic [CLKDIV_W-1:0] preCnt_r;
  logic [BASE_W-1:0] baseCnt_r;
  logic [PERIOD_W-1:0] periodCnt_r;
  logic enabled;
  logic noLimit;
  logic waiting;
  logic [CLKDIV_W-1:0] divTop;
  logic [BASE_W-1:0] baseTop;
  logic [PERIOD_W-1:0] periodTop;
  logic preTick;
  logic baseWrap;
  logic expire;

  // field decode; a zero divider or base length still counts one step
  always_comb begin
    enabled = (setting != STRETCH_OFF);
    noLimit = ALLOW_FOREVER && (setting == STRETCH_FOREVER);
    waiting = (txRole && txEmpty) || (rxRole && rxFull);
    divTop = (clkDiv == '0) ? '0 : clkDiv - CLKDIV_W'(1);
    baseTop = (baseLen == '0) ? '0 : baseLen - BASE_W'(1);
    periodTop = (PERIOD_ONE << setting) - PERIOD_ONE;
    preTick = (preCnt_r >= divTop);
    baseWrap = preTick && (baseCnt_r >= baseTop);
    expire = !noLimit && baseWrap && (periodCnt_r == periodTop);
  end

  assign hold = (state_r == ST_HOLD);
  // fifo release has priority, so a late timeout is never flagged
  assign timeout = hold && enabled && waiting && expire;

  // stretch starts only at a byte-boundary falling edge of SCL
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (enabled && sclFall && boundary && waiting) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!enabled || !waiting) begin
            state_r <= ST_IDLE;
          end else if (expire) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // timeout counters sit at zero outside a stretch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= '0;
      baseCnt_r <= '0;
      periodCnt_r <= '0;
    end else if (state_r != ST_HOLD) begin
      preCnt_r <= '0;
      baseCnt_r <= '0;
      periodCnt_r <= '0;
    end else begin
      preCnt_r <= preTick ? '0 : preCnt_r + CLKDIV_W'(1);
      if (baseWrap) begin
        baseCnt_r <= '0;
        periodCnt_r <= periodCnt_r + PERIOD_W'(1);
      end else if (preTick) begin
        baseCnt_r <= baseCnt_r + BASE_W'(1);
      end
    end
  end
endmodule : stretch_half
`default_nettype wire

// ---- hdl/i2c_auto_clock_stretch.sv ----
// automatic SCL stretch, timeout flags and start/stop detector
//
// Design decision made here: strobed register access.
`default_nettype none
module i2c_auto_clock_stretch
  import i2c_stretch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [REG_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_W-1:0] regRdData,
  // bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  // byte engine roles and phase points
  input wire logic masterTxRole,
  input wire logic masterRxRole,
  input wire logic masterBoundary,
  input wire logic slaveTxRole,
  input wire logic slaveRxRole,
  input wire logic slaveBoundary,
  // fifo fill levels
  input wire logic [FIFO_CNT_W-1:0] masterTxLevel,
  input wire logic [FIFO_CNT_W-1:0] masterRxLevel,
  input wire logic [FIFO_CNT_W-1:0] slaveTxLevel,
  input wire logic [FIFO_CNT_W-1:0] slaveRxLevel,
  // clock configuration
  input wire logic [DIV_W-1:0] sclDivHigh,
  input wire logic [DIV_W-1:0] sclDivLow,
  input wire logic [CLKDIV_W-1:0] sysClkDiv,
  // status
  output logic busOccupied,
  output logic startDetected,
  output logic stopDetected,
  output logic masterStretching,
  output logic slaveStretching,
  output logic masterTimeoutFlag,
  output logic slaveTimeoutFlag
);
  // pin synchronisers and edge history
  logic sclMeta_r;
  logic sclSync_r;
  logic sclPrev_r;
  logic sdaMeta_r;
  logic sdaSync_r;
  logic sdaPrev_r;
  // register state
  logic [SET_W-1:0] masterSet_r;
  logic [SET_W-1:0] slaveSet_r;
  logic masterFlag_r;
  logic slaveFlag_r;
  logic [REG_W-1:0] rdData_r;
  logic sclOe_r;
  logic sclOut_r;
  logic masterStr_r;
  logic slaveStr_r;
  logic busy_r;
  logic start_r;
  logic stop_r;
  // decode
  logic wrShared;
  logic wrCtrl;
  logic rdCtrl;
  logic detReset;
  logic [REG_W-1:0] ctrlView;
  logic [REG_W-1:0] rdData_nxt;
  // bus events
  logic sclFall;
  logic startEv;
  logic stopEv;
  // stretch engine
  logic [BASE_W-1:0] baseLen;
  logic masterHold;
  logic slaveHold;
  logic masterTimeout;
  logic slaveTimeout;
  logic masterTxEmpty;
  logic masterRxFull;
  logic slaveTxEmpty;
  logic slaveRxFull;

  // two flops on each pin; only the second flop is looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
    end else begin
      sclMeta_r <= sclIn;
      sclSync_r <= sclMeta_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
    end
  end

  // address decode for the two mapped words
  always_comb begin
    wrShared = 1'b0;
    wrCtrl = 1'b0;
    rdCtrl = 1'b0;
    if (regWr && regAddr == SHARED_RESET_ADDR) begin
      wrShared = 1'b1;
    end else if (regWr && regAddr == STRETCH_CTRL_ADDR) begin
      wrCtrl = 1'b1;
    end
    if (regRd && regAddr == STRETCH_CTRL_ADDR) begin
      rdCtrl = 1'b1;
    end
  end

  // writing zero to the reset bit does nothing at all
  assign detReset = wrShared && regWrData[DETECTOR_RESET_BIT];

  // edges on the synchronised lines
  always_comb begin
    sclFall = sclPrev_r && !sclSync_r;
    startEv = sclSync_r && sclPrev_r && sdaPrev_r && !sdaSync_r;
    stopEv = sclSync_r && sclPrev_r && !sdaPrev_r && sdaSync_r;
  end

  // edge history tracks the synced lines every cycle, so a detector
  // reset leaves no stale level behind to fake an edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclSync_r;
      sdaPrev_r <= sdaSync_r;
    end
  end

  // start/stop pulses, masked while the detector is being reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      start_r <= startEv && !detReset;
      stop_r <= stopEv && !detReset;
    end
  end

  // bus occupied from start to stop; a detector reset discards
  // whatever edge arrives in the same cycle, being a reinitialise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (detReset) begin
      busy_r <= 1'b0;
    end else if (startEv) begin
      busy_r <= 1'b1;
    end else if (stopEv) begin
      busy_r <= 1'b0;
    end
  end

  // software settings for both halves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterSet_r <= STRETCH_OFF;
      slaveSet_r <= STRETCH_OFF;
    end else if (wrCtrl) begin
      masterSet_r <= regWrData[MASTER_SET_LSB +: SET_W];
      slaveSet_r <= regWrData[SLAVE_SET_LSB +: SET_W];
    end
  end

  // timeout flags: a timeout in the reading cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterFlag_r <= 1'b0;
      slaveFlag_r <= 1'b0;
    end else begin
      if (masterTimeout) begin
        masterFlag_r <= 1'b1;
      end else if (rdCtrl) begin
        masterFlag_r <= 1'b0;
      end
      if (slaveTimeout) begin
        slaveFlag_r <= 1'b1;
      end else if (rdCtrl) begin
        slaveFlag_r <= 1'b0;
      end
    end
  end

  // read view; the shared word is write-only and reads as zero
  always_comb begin
    ctrlView = REG_RESET;
    ctrlView[MASTER_SET_LSB +: SET_W] = masterSet_r;
    ctrlView[SLAVE_SET_LSB +: SET_W] = slaveSet_r;
    ctrlView[MASTER_FLAG_BIT] = masterFlag_r;
    ctrlView[SLAVE_FLAG_BIT] = slaveFlag_r;
    rdData_nxt = REG_RESET;
    if (rdCtrl) begin
      rdData_nxt = ctrlView;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= REG_RESET;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // fifo conditions; a receive fifo is full at two bytes
  always_comb begin
    masterTxEmpty = (masterTxLevel == FIFO_NONE);
    slaveTxEmpty = (slaveTxLevel == FIFO_NONE);
    masterRxFull = (masterRxLevel >= FIFO_DEPTH);
    slaveRxFull = (slaveRxLevel >= FIFO_DEPTH);
  end

  // base length from divisors only, never from the live bit rate
  always_comb begin
    baseLen = BASE_W'(sclDivHigh) + BASE_W'(sclDivLow);
    baseLen = (baseLen == '0) ? '0 : baseLen - BASE_W'(1);
  end

  // master half: 1111 means stretch with no timeout
  stretch_half #(
    .ALLOW_FOREVER(1'b1)
  ) u_master (
    .clk(clk),
    .rst(rst),
    .setting(masterSet_r),
    .sclFall(sclFall),
    .boundary(masterBoundary),
    .txRole(masterTxRole),
    .rxRole(masterRxRole),
    .txEmpty(masterTxEmpty),
    .rxFull(masterRxFull),
    .baseLen(baseLen),
    .clkDiv(sysClkDiv),
    .hold(masterHold),
    .timeout(masterTimeout)
  );

  // slave half: every nonzero value is a timeout exponent
  stretch_half #(
    .ALLOW_FOREVER(1'b0)
  ) u_slave (
    .clk(clk),
    .rst(rst),
    .setting(slaveSet_r),
    .sclFall(sclFall),
    .boundary(slaveBoundary),
    .txRole(slaveTxRole),
    .rxRole(slaveRxRole),
    .txEmpty(slaveTxEmpty),
    .rxFull(slaveRxFull),
    .baseLen(baseLen),
    .clkDiv(sysClkDiv),
    .hold(slaveHold),
    .timeout(slaveTimeout)
  );

  // open-drain SCL: drive low while either half stretches; the
  // others on the bus simply see a slow clock and wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclOe_r <= 1'b0;
      sclOut_r <= 1'b0;
      masterStr_r <= 1'b0;
      slaveStr_r <= 1'b0;
    end else begin
      sclOe_r <= masterHold || slaveHold;
      sclOut_r <= 1'b0;
      // same timing as the drive, so status never disagrees with sclOe
      masterStr_r <= masterHold;
      slaveStr_r <= slaveHold;
    end
  end

  assign regRdData = rdData_r;
  assign sclOut = sclOut_r;
  assign sclOe = sclOe_r;
  assign busOccupied = busy_r;
  assign startDetected = start_r;
  assign stopDetected = stop_r;
  assign masterStretching = masterStr_r;
  assign slaveStretching = slaveStr_r;
  assign masterTimeoutFlag = masterFlag_r;
  assign slaveTimeoutFlag = slaveFlag_r;
endmodule : i2c_auto_clock_stretch
`default_nettype wire

// ---- verification/i2c_stretch_asserts.sv ----
// port assertions for the automatic stretch block
`default_nettype none
module i2c_stretch_asserts
  import i2c_stretch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [REG_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic masterTxRole,
  input wire logic slaveRxRole,
  input wire logic [FIFO_CNT_W-1:0] masterTxLevel,
  input wire logic [FIFO_CNT_W-1:0] slaveRxLevel,
  input wire logic busOccupied,
  input wire logic masterStretching,
  input wire logic slaveStretching,
  input wire logic masterTimeoutFlag,
  input wire logic slaveTimeoutFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [7:0] set_r;
  logic ctlRd;
  assign ctlRd = regRd && regAddr == STRETCH_CTRL_ADDR;
  // shadow of both settings; release takes 3 cycles, 4 leaves margin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_r <= 8'h00;
    end else if (regWr && regAddr == STRETCH_CTRL_ADDR) begin
      set_r <= regWrData[7:0];
    end
  end
  chk_mflag_read: assert property (
    ctlRd && !masterStretching |=> !masterTimeoutFlag)
    else $error("master flag survived a read");
  chk_sflag_read: assert property (
    ctlRd && !slaveStretching |=> !slaveTimeoutFlag)
    else $error("slave flag survived a read");
  chk_mflag_cause: assert property (
    $rose(masterTimeoutFlag) |-> $past(masterStretching)
      && $past(set_r[3:0]) != STRETCH_FOREVER)
    else $error("master flag without a timed stretch");
  chk_sflag_cause: assert property (
    $rose(slaveTimeoutFlag) |-> $past(slaveStretching))
    else $error("slave flag without a stretch");
  chk_moff_quiet: assert property (
    (set_r[3:0] == STRETCH_OFF) [*4] |-> !masterStretching)
    else $error("master stretched while off");
  chk_soff_quiet: assert property (
    (set_r[7:4] == STRETCH_OFF) [*4] |-> !slaveStretching)
    else $error("slave stretched while off");
  chk_busy_reset: assert property (
    regWr && regAddr == SHARED_RESET_ADDR && regWrData[0] |=> !busOccupied)
    else $error("bus occupied after detector reset");
  chk_mtx_release: assert property (
    (masterTxRole && masterTxLevel != FIFO_NONE) [*4] |-> !masterStretching)
    else $error("master held with data to send");
  chk_srx_release: assert property (
    (slaveRxRole && slaveRxLevel != FIFO_DEPTH) [*4] |-> !slaveStretching)
    else $error("slave held with room to receive");
endmodule : i2c_stretch_asserts
`default_nettype wire

// ---- verification/i2c_bus_peer.sv ----
// far-side bus party: open-drain SCL and SDA with pull-ups
`default_nettype none
module i2c_bus_peer (
  input wire logic clk,
  input wire logic sclOut,
  input wire logic sclOe,
  output logic sclLine,
  output logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  // wired-and of both parties; a released line floats high
  assign sclLine = !sclLow && !(sclOe && !sclOut);
  assign sdaLine = !sdaLow;
  task automatic scl_drive(input logic low);
    sclLow <= low;
  endtask : scl_drive
  // a clock held low is a stretch: wait for the rise, bounded
  task automatic wait_high();
    int k;
    for (k = 0; k < 2000 && !sclLine; k++) @(posedge clk);
  endtask : wait_high
  // start: SDA falls with SCL high; stop: SDA rises with SCL high
  task automatic bus_cond(input logic stop);
    sclLow <= 1'b1;
    sdaLow <= stop;
    repeat (4) @(posedge clk);
    sclLow <= 1'b0;
    repeat (4) @(posedge clk);
    sdaLow <= !stop;
    repeat (8) @(posedge clk);
  endtask : bus_cond
endmodule : i2c_bus_peer
`default_nettype wire

// ---- verification/test_i2c_auto_clock_stretch.sv ----
// self-checking bench for the automatic stretch block
`default_nettype none
module test_i2c_auto_clock_stretch;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_stretch_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] regAddr = 32'h0;
  logic [15:0] regWrData = 16'h0;
  logic [15:0] regRdData;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sclOut, sclOe, sclLine, sdaLine, busOccupied;
  logic startDetected, stopDetected;
  logic [1:0] str, flg;
  logic bnd = 1'b0;
  logic [3:0] role = 4'h0;
  logic [1:0] lvl [4] = '{2'h1, 2'h0, 2'h1, 2'h0};
  logic [7:0] divHi = 8'h02;
  logic [7:0] divLo = 8'h02;
  logic [2:0] clkDiv = 3'h2;
  int mismatches = 0;
  int checked = 0;
  int starts = 0;
  int stops = 0;
  int i, n;
  i2c_auto_clock_stretch dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .masterTxRole(role[0]), .masterRxRole(role[1]),
    .masterBoundary(bnd), .slaveTxRole(role[2]), .slaveRxRole(role[3]),
    .slaveBoundary(bnd), .masterTxLevel(lvl[0]), .masterRxLevel(lvl[1]),
    .slaveTxLevel(lvl[2]), .slaveRxLevel(lvl[3]), .sclDivHigh(divHi),
    .sclDivLow(divLo), .sysClkDiv(clkDiv), .busOccupied(busOccupied),
    .startDetected(startDetected), .stopDetected(stopDetected),
    .masterStretching(str[0]), .slaveStretching(str[1]),
    .masterTimeoutFlag(flg[0]), .slaveTimeoutFlag(flg[1]));
  i2c_bus_peer peer (.clk(clk), .sclOut(sclOut), .sclOe(sclOe),
    .sclLine(sclLine), .sdaLine(sdaLine));
  initial begin
    forever #4 clk = ~clk;
  end
  // pulses stand one cycle, so they are counted at every edge
  always @(posedge clk) begin
    if (startDetected === 1'b1) starts++;
    if (stopDetected === 1'b1) stops++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bus tasks begin on an edge so a strobe never gets two values at once
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    check(regRdData, exp);
  endtask : rd
  // one SCL fall with one role; counts the cycles the block holds SCL
  task automatic episode(input int sel, input logic [1:0] lv,
                         input int relAt, output int cnt);
    int w;
    @(posedge clk);
    role <= 4'h1 << sel;
    bnd <= 1'b1;
    lvl[sel] <= lv;
    peer.scl_drive(1'b1);
    cnt = 0;
    for (w = 0; w < 900; w++) begin
      @(posedge clk);
      if (w == 6) peer.scl_drive(1'b0);
      // while SCL is held, the status must name the half doing it
      if (sclOe === 1'b1) begin
        cnt++;
        check({14'h0, str}, sel < 2 ? 16'h0001 : 16'h0002);
      end else if (cnt > 0 || w > 30) break;
      if (cnt == relAt) lvl[sel] <= 2'h1;
    end
    peer.wait_high();
    role <= 4'h0;
    bnd <= 1'b0;
    lvl[sel] <= sel[0] ? 2'h0 : 2'h1;
  endtask : episode
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(STRETCH_CTRL_ADDR, REG_RESET);
    rd(SHARED_RESET_ADDR, 16'h0000);
    rd(32'h40003054, 16'h0000);
    wr(STRETCH_CTRL_ADDR, 16'hFF11);
    rd(STRETCH_CTRL_ADDR, 16'h0011);
    // timeout is 2 * (2+2-1) * 2^1 = 12 cycles for every role
    for (i = 0; i < 4; i++) begin
      episode(i, i[0] ? FIFO_DEPTH : FIFO_NONE, 9999, n);
      check(n[15:0], 16'h000C);
      check({14'h0, flg}, i < 2 ? 16'h0001 : 16'h0002);
      rd(STRETCH_CTRL_ADDR, i < 2 ? 16'h0111 : 16'h0211);
      rd(STRETCH_CTRL_ADDR, 16'h0011);
      check({14'h0, flg}, 16'h0000);
    end
    for (i = 0; i < 4; i++) begin
      episode(i, i[0] ? FIFO_DEPTH : FIFO_NONE, 4, n);
      check({15'h0, n >= 4 && n <= 8}, 16'h0001);
      rd(STRETCH_CTRL_ADDR, 16'h0011);
    end
    // one byte in any fifo is neither empty nor full
    for (i = 0; i < 4; i++) begin
      episode(i, 2'h1, 9999, n);
      check(n[15:0], 16'h0000);
    end
    wr(STRETCH_CTRL_ADDR, 16'h0033);
    for (i = 0; i < 4; i += 2) begin
      episode(i, FIFO_NONE, 9999, n);
      check(n[15:0], 16'h0030);
    end
    rd(STRETCH_CTRL_ADDR, 16'h0333);
    wr(STRETCH_CTRL_ADDR, 16'h003F);
    episode(1, FIFO_DEPTH, 200, n);
    check({15'h0, n >= 200 && n <= 204}, 16'h0001);
    rd(STRETCH_CTRL_ADDR, 16'h003F);
    divHi <= 8'h01;
    divLo <= 8'h01;
    clkDiv <= 3'h0;
    wr(STRETCH_CTRL_ADDR, 16'h0022);
    for (i = 1; i < 4; i += 2) begin
      episode(i, FIFO_DEPTH, 9999, n);
      check(n[15:0], 16'h0004);
    end
    wr(STRETCH_CTRL_ADDR, 16'h0000);
    for (i = 0; i < 4; i++) begin
      episode(i, i[0] ? FIFO_DEPTH : FIFO_NONE, 9999, n);
      check(n[15:0], 16'h0000);
    end
    peer.bus_cond(1'b0);
    check({15'h0, busOccupied}, 16'h0001);
    wr(SHARED_RESET_ADDR, 16'hFFFE);
    @(posedge clk);
    check({15'h0, busOccupied}, 16'h0001);
    wr(SHARED_RESET_ADDR, 16'h0001);
    @(posedge clk);
    check({15'h0, busOccupied}, 16'h0000);
    peer.bus_cond(1'b1);
    check({starts[7:0], stops[7:0]}, 16'h0101);
    check({15'h0, busOccupied}, 16'h0000);
    check({15'h0, sclOut}, 16'h0000);
    tally_and_finish();
  end
endmodule : test_i2c_auto_clock_stretch
bind i2c_auto_clock_stretch i2c_stretch_asserts chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .masterTxRole(masterTxRole),
  .slaveRxRole(slaveRxRole), .masterTxLevel(masterTxLevel),
  .slaveRxLevel(slaveRxLevel), .busOccupied(busOccupied),
  .masterStretching(masterStretching), .slaveStretching(slaveStretching),
  .masterTimeoutFlag(masterTimeoutFlag), .slaveTimeoutFlag(slaveTimeoutFlag));
`default_nettype wire
